// ==== verilog/ssc_pkg.sv ====
package ssc_pkg;

  localparam int          SSC_W        = 16;
  localparam int          SSC_NSETS    = 4;
  localparam int          SSC_SB_W     = 8;
  localparam logic [15:0] SSC_REG_RST  = 16'h0000;

  // Register set index, also the order of the event ports
  localparam int SSC_SET_STD  = 0;
  localparam int SSC_SET_OPER = 1;
  localparam int SSC_SET_MEAS = 2;
  localparam int SSC_SET_QUES = 3;

  // Status byte bit positions
  localparam int SSC_SB_MEAS  = 0;
  localparam int SSC_SB_ERRQ  = 2;
  localparam int SSC_SB_QUES  = 3;
  localparam int SSC_SB_OUTQ  = 4;
  localparam int SSC_SB_STD   = 5;
  localparam int SSC_SB_MSS   = 6;
  localparam int SSC_SB_OPER  = 7;

  // APB byte addresses
  localparam logic [11:0] SSC_A_COND    = 12'h000;
  localparam logic [11:0] SSC_A_EVENT   = 12'h010;
  localparam logic [11:0] SSC_A_ENABLE  = 12'h020;
  localparam logic [11:0] SSC_A_STB     = 12'h030;
  localparam logic [11:0] SSC_A_SRE     = 12'h034;
  localparam logic [11:0] SSC_A_CMD     = 12'h038;
  localparam logic [11:0] SSC_A_QSTAT   = 12'h03C;
  localparam logic [11:0] SSC_A_OUTQ_RD = 12'h040;
  localparam logic [11:0] SSC_A_ERRQ_RD = 12'h044;

  // Command register bits
  localparam int SSC_CMD_CLS      = 0;
  localparam int SSC_CMD_STPRESET = 1;
  localparam int SSC_CMD_QCLEAR   = 2;
  localparam int SSC_CMD_SYSPRES  = 3;

  localparam int SSC_QDEPTH = 8;
  localparam int SSC_QPW    = 4;

  typedef logic [SSC_W-1:0] ssc_word_t;

endpackage : ssc_pkg

// ==== verilog/ssc_queue.sv ====
`timescale 1ns/1ps
module ssc_queue
  import ssc_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  push,
  input  wire logic [SSC_W-1:0]      push_data,
  input  wire logic                  pop,
  input  wire logic                  flush,
  output logic                       pending,
  output logic [SSC_W-1:0]           head,
  output logic [SSC_QPW-1:0]         count
);

  typedef struct packed {
    logic [SSC_QPW-2:0] rd;
    logic [SSC_QPW-2:0] wr;
    logic [SSC_QPW-1:0] cnt;
  } ssc_q_s;

  ssc_q_s    q_reg;
  ssc_q_s    q_next;
  ssc_word_t mem [SSC_QDEPTH];
  logic      do_push;
  logic      do_pop;

  // Push dropped when full unless a pop is taken the same cycle; flush wins over both
  always_comb begin
    do_pop  = pop && (q_reg.cnt != '0) && !flush;
    do_push = push && !flush &&
              (q_reg.cnt != SSC_QPW'(SSC_QDEPTH) || do_pop);
    q_next  = q_reg;
    if (flush) begin
      q_next = '0;
    end else begin
      if (do_push) q_next.wr = q_reg.wr + 1'b1;
      if (do_pop)  q_next.rd = q_reg.rd + 1'b1;
      q_next.cnt = q_reg.cnt + SSC_QPW'(do_push) - SSC_QPW'(do_pop);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  always_ff @(posedge pclk) begin
    if (do_push) mem[q_reg.wr] <= push_data;
  end

  assign pending = (q_reg.cnt != '0);
  assign head    = pending ? mem[q_reg.rd] : '0;
  assign count   = q_reg.cnt;

endmodule : ssc_queue

// ==== verilog/ssc_status.sv ====
// How it works
// RL1 - Power-on clears all registers, empties queues
// RL2 - Condition registers are live, read-only, unlatched
// RL3 - Event bits latch to one until read, clear-status or reset
// RL4 - Set summary is OR of event AND enable
// RL5 - Responses and errors enter their queues
// RL6 - Non-empty queue raises its status bit
// RL7 - Status byte gathers four sets, two queues
// RL8 - Master summary from enabled status byte bits
// RL9 - Clear-status zeros all four event registers
// RL10 - Status preset zeros three enable registers
// RL11 - Standard enable touched only by its write
// RL12 - Writing zero clears an enable register
// RL13 - Clear-status or queue clear empties errors
// RL14 - Status preset keeps error queue
// RL15 - System preset changes nothing
// RL16 - Reading an event register clears it
// RL17 - Only enable registers, the service request enable and the command word are writable
// RL18 - Output queue at B4, error queue at B2
// RL19 - New event beats a same-cycle clear
// RL20 - Summaries registered, one clock latency
`timescale 1ns/1ps
module ssc_status
  import ssc_pkg::*;
(
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic                            pready,
  output logic                            pslverr,
  output logic [31:0]                     prdata,
  input  wire logic [SSC_NSETS*SSC_W-1:0] cond_in,
  input  wire logic [SSC_NSETS*SSC_W-1:0] event_in,
  input  wire logic                       resp_push,
  input  wire logic [SSC_W-1:0]           resp_data,
  input  wire logic                       err_push,
  input  wire logic [SSC_W-1:0]           err_data,
  output logic                            master_service_summary,
  output logic [SSC_SB_W-1:0]             status_byte
);

  typedef struct packed {
    logic [SSC_NSETS-1:0][SSC_W-1:0] cond;
    logic [SSC_NSETS-1:0][SSC_W-1:0] evt;
    logic [SSC_NSETS-1:0][SSC_W-1:0] ena;
    logic [SSC_SB_W-1:0]             sre;
    logic [SSC_SB_W-1:0]             stb;
    logic                            mss;
    logic [31:0]                     rdata;
    logic                            err;
    logic                            rdy;
  } ssc_st_s;

  ssc_st_s st_reg;
  ssc_st_s st_next;

  logic                  acc;
  logic                  wr_acc;
  logic                  rd_acc;
  logic [1:0]            set_sel;
  logic [11:0]           page;
  logic                  cmd_cls;
  logic                  cmd_stpre;
  logic                  cmd_qclr;
  logic                  outq_pend;
  logic                  errq_pend;
  logic [SSC_W-1:0]      outq_head;
  logic [SSC_W-1:0]      errq_head;
  logic [SSC_QPW-1:0]    outq_cnt;
  logic [SSC_QPW-1:0]    errq_cnt;
  logic                  outq_pop;
  logic                  errq_pop;
  logic [SSC_NSETS-1:0]  set_sum;
  logic [SSC_NSETS-1:0]  evt_rd;
  logic [SSC_NSETS-1:0]  ena_wr;
  logic                  known;

  // Zero wait state slave; pready high in the access phase
  assign acc     = psel && penable;
  assign wr_acc  = acc && pwrite;
  assign rd_acc  = acc && !pwrite;
  assign set_sel = paddr[3:2];
  assign page    = {paddr[11:4], 4'h0};

  assign cmd_cls   = wr_acc && paddr == SSC_A_CMD && pwdata[SSC_CMD_CLS];
  assign cmd_stpre = wr_acc && paddr == SSC_A_CMD &&
                     pwdata[SSC_CMD_STPRESET];
  assign cmd_qclr  = wr_acc && paddr == SSC_A_CMD &&
                     pwdata[SSC_CMD_QCLEAR];
  assign outq_pop  = rd_acc && paddr == SSC_A_OUTQ_RD;
  assign errq_pop  = rd_acc && paddr == SSC_A_ERRQ_RD;

  ssc_queue u_outq (
    .pclk      (pclk),
    .presetn   (presetn),
    .push      (resp_push),                               // [RL5]
    .push_data (resp_data),
    .pop       (outq_pop),
    .flush     (1'b0),
    .pending   (outq_pend),
    .head      (outq_head),
    .count     (outq_cnt)
  );

  ssc_queue u_errq (
    .pclk      (pclk),
    .presetn   (presetn),
    .push      (err_push),                                // [RL5]
    .push_data (err_data),
    .pop       (errq_pop),
    .flush     (cmd_cls || cmd_qclr),               // [RL13] [RL14]
    .pending   (errq_pend),
    .head      (errq_head),
    .count     (errq_cnt)
  );

  genvar g;
  generate
    for (g = 0; g < SSC_NSETS; g++) begin : g_set
      assign evt_rd[g]  = rd_acc && page == SSC_A_EVENT &&
                          set_sel == 2'(g);                 // [RL16]
      // Standard enable ignores both presets
      assign ena_wr[g]  = wr_acc && page == SSC_A_ENABLE &&
                          set_sel == 2'(g);                 // [RL17]
      assign set_sum[g] = |(st_reg.evt[g] & st_reg.ena[g]); // [RL4]
    end
  endgenerate

  always_comb begin
    st_next      = st_reg;
    st_next.rdy  = 1'b0;
    st_next.err  = 1'b0;
    st_next.cond = cond_in;                                 // [RL2]
    for (int i = 0; i < SSC_NSETS; i++) begin
      // Clear first, so a same-cycle event still lands
      if (cmd_cls || evt_rd[i]) begin
        st_next.evt[i] = SSC_REG_RST;                       // [RL9]
      end
      st_next.evt[i] = st_next.evt[i] |
                       event_in[i*SSC_W +: SSC_W];     // [RL3] [RL19]
      if (cmd_stpre && i != SSC_SET_STD) begin
        st_next.ena[i] = SSC_REG_RST;                  // [RL10] [RL11]
      end
      if (ena_wr[i]) begin
        st_next.ena[i] = pwdata[SSC_W-1:0];            // [RL12] [RL17]
      end
    end
    if (wr_acc && paddr == SSC_A_SRE) begin
      st_next.sre = pwdata[SSC_SB_W-1:0];                   // [RL12]
    end
    // Summaries follow inputs, no latching in the status byte
    st_next.stb                = '0;
    st_next.stb[SSC_SB_MEAS]   = set_sum[SSC_SET_MEAS];     // [RL7]
    st_next.stb[SSC_SB_QUES]   = set_sum[SSC_SET_QUES];
    st_next.stb[SSC_SB_STD]    = set_sum[SSC_SET_STD];
    st_next.stb[SSC_SB_OPER]   = set_sum[SSC_SET_OPER];
    st_next.stb[SSC_SB_OUTQ]   = outq_pend;            // [RL6] [RL18]
    st_next.stb[SSC_SB_ERRQ]   = errq_pend;            // [RL6] [RL18]
    st_next.stb[SSC_SB_MSS]    = 1'b0;
    st_next.mss = |(st_next.stb & st_reg.sre);         // [RL8] [RL20]
    st_next.stb[SSC_SB_MSS]    = st_next.mss;
    // Read mux; system preset bit is accepted and ignored
    known = 1'b1;
    st_next.rdata = '0;
    unique case (page)
      SSC_A_COND:   st_next.rdata = {16'h0000, st_reg.cond[set_sel]};
      SSC_A_EVENT:  st_next.rdata = {16'h0000, st_reg.evt[set_sel]};
      SSC_A_ENABLE: st_next.rdata = {16'h0000, st_reg.ena[set_sel]};
      default: begin
        unique case (paddr)
          SSC_A_STB:     st_next.rdata = {24'h00_0000, st_reg.stb};
          SSC_A_SRE:     st_next.rdata = {24'h00_0000, st_reg.sre};
          SSC_A_CMD:     st_next.rdata = 32'h0000_0000;    // [RL15]
          SSC_A_QSTAT:   st_next.rdata = {24'h00_0000, errq_cnt,
                                          outq_cnt};
          SSC_A_OUTQ_RD: st_next.rdata = {16'h0000, outq_head};
          SSC_A_ERRQ_RD: st_next.rdata = {16'h0000, errq_head};
          default:       known = 1'b0;
        endcase
      end
    endcase
    // Writes to read-only words and any access to unmapped words raise pslverr
    if (acc && !st_reg.rdy) begin
      st_next.rdy = 1'b1;
      st_next.err = !known || (pwrite && (page == SSC_A_COND ||
                    page == SSC_A_EVENT || paddr == SSC_A_STB ||
                    paddr == SSC_A_QSTAT || paddr == SSC_A_OUTQ_RD ||
                    paddr == SSC_A_ERRQ_RD));               // [RL17]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;                                         // [RL1]
    end else begin
      st_reg <= st_next;
    end
  end

  assign pready                 = 1'b1;
  assign pslverr                = acc && st_next.err;
  assign prdata                 = st_next.rdata;
  assign master_service_summary = st_reg.mss;
  assign status_byte            = st_reg.stb;

endmodule : ssc_status

// ==== bench/ssc_status_checker.sv ====
`timescale 1ns/1ps
module ssc_status_checker
  import ssc_pkg::*;
(
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [11:0]                paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [31:0]                prdata,
  input wire logic                       pslverr,
  input wire logic [SSC_NSETS*SSC_W-1:0] cond_in,
  input wire logic                       resp_push,
  input wire logic                       err_push,
  input wire logic                       master_service_summary,
  input wire logic [SSC_SB_W-1:0]        status_byte
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr(a);
    psel && penable && pwrite && paddr == a;
  endsequence
  sequence s_cmd(b);
    s_wr(SSC_A_CMD) ##0 pwdata[b];
  endsequence
  a_mss_match: assert property (
    master_service_summary == status_byte[SSC_SB_MSS])
    else $error("master bit differs");
  a_outq_rise: assert property (
    $rose(status_byte[SSC_SB_OUTQ]) |-> $past(resp_push, 2))
    else $error("output bit rose alone");
  a_errq_rise: assert property (
    $rose(status_byte[SSC_SB_ERRQ]) |-> $past(err_push, 2))
    else $error("error bit rose alone");
  a_ro_refused: assert property (s_wr(SSC_A_STB) |-> pslverr)
    else $error("read-only write taken");
  a_hole_refused: assert property (
    psel && penable && paddr == 12'h048 |-> pslverr)
    else $error("unmapped access taken");
  a_cond_live: assert property (
    psel && penable && !pwrite && paddr == SSC_A_COND && $stable(cond_in)
    |-> prdata == {16'h0000, cond_in[15:0]})
    else $error("condition read stale");
  a_errq_flush: assert property (
    s_cmd(SSC_CMD_CLS) or s_cmd(SSC_CMD_QCLEAR)
    |-> ##2 !status_byte[SSC_SB_ERRQ])
    else $error("error queue kept");
  a_errq_kept: assert property (
    (s_cmd(SSC_CMD_STPRESET) or s_cmd(SSC_CMD_SYSPRES)) ##0
    (!pwdata[SSC_CMD_CLS] && !pwdata[SSC_CMD_QCLEAR]
     && status_byte[SSC_SB_ERRQ]) |-> ##2 status_byte[SSC_SB_ERRQ])
    else $error("error queue lost");
endmodule : ssc_status_checker
bind ssc_status ssc_status_checker chk_u (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .cond_in,
  .resp_push, .err_push, .master_service_summary, .status_byte);

// ==== bench/ssc_host.sv ====
`timescale 1ns/1ps
module ssc_host (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb
);
  int tmo = 0;
  // Full words only
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
  end
  // Zero data clears a whole enable register
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) tmo++;
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : xfer
endmodule : ssc_host

// ==== bench/status_summary_and_clear_logic_tb.sv ====
`timescale 1ns/1ps
module status_summary_and_clear_logic_tb;
  import ssc_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, resp_push = 1'b0;
  logic        err_push = 1'b0, psel, penable, pwrite, pready, pslverr;
  logic        mss, e;
  logic [63:0] cond_in = '0, event_in = '0;
  logic [15:0] resp_data = '0, err_data = '0, ev[4], en[4], q[$];
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb;
  logic [7:0]  sbyte, sre, s;
  int          fails = 0, checks = 0, oq = 0, eq = 0;
  always #5 pclk = ~pclk;
  ssc_status dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .pslverr, .prdata, .cond_in, .event_in,
    .resp_push, .resp_data, .err_push, .err_data,
    .master_service_summary(mss), .status_byte(sbyte));
  ssc_host host_u (.pclk, .pready, .pslverr, .prdata, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb);
  function automatic logic [7:0] exp_sb();
    logic [7:0] t;
    t = '0;
    t[SSC_SB_STD]  = |(ev[SSC_SET_STD] & en[SSC_SET_STD]);
    t[SSC_SB_OPER] = |(ev[SSC_SET_OPER] & en[SSC_SET_OPER]);
    t[SSC_SB_MEAS] = |(ev[SSC_SET_MEAS] & en[SSC_SET_MEAS]);
    t[SSC_SB_QUES] = |(ev[SSC_SET_QUES] & en[SSC_SET_QUES]);
    t[SSC_SB_OUTQ] = oq > 0;
    t[SSC_SB_ERRQ] = eq > 0;
    t[SSC_SB_MSS]  = |(t & sre);
    return t;
  endfunction : exp_sb
  task chk(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, g, x);
    end
  endtask : chk
  task rd(input logic [11:0] a, input logic [31:0] x);
    host_u.xfer(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask : rd
  task wr(input logic [11:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, r, e);
  endtask : wr
  task pulse(input logic [63:0] v);
    @(posedge pclk);
    event_in <= v;
    @(posedge pclk);
    event_in <= '0;
    foreach (ev[i]) ev[i] |= v[16*i +: 16];
  endtask : pulse
  task tally_and_finish();
    fails += host_u.tmo;
    if (fails == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h7ea3));
    foreach (ev[i]) {ev[i], en[i]} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    cond_in <= {$urandom, $urandom};
    rd(SSC_A_STB, 32'h0);
    rd(SSC_A_QSTAT, 32'h0);
    rd(SSC_A_COND, {16'h0, cond_in[15:0]});
    wr(SSC_A_STB, 32'hFF);
    chk({31'h0, e}, 32'h1);
    rd(12'h048, 32'h0);
    chk({31'h0, e}, 32'h1);
    sre = 8'($urandom);
    wr(SSC_A_SRE, {24'h0, sre});
    for (int c = 0; c < 4; c++) begin
      pulse({$urandom, $urandom});
      @(posedge pclk);
      {resp_push, err_push, resp_data, err_data} <= {2'b11, 32'($urandom)};
      @(posedge pclk);
      {resp_push, err_push} <= 2'b00;
      q.push_back(resp_data);
      oq++;
      eq++;
      for (int i = 0; i < 4; i++) begin
        en[i] = 16'($urandom);
        wr(SSC_A_ENABLE + 12'(4*i), {16'h0, en[i]});
      end
      s = exp_sb();
      rd(SSC_A_STB, {24'h0, s});
      chk({31'h0, mss}, {31'h0, s[SSC_SB_MSS]});
      rd(SSC_A_OUTQ_RD, {16'h0, q.pop_front()});
      oq--;
      wr(SSC_A_CMD, 32'h1 << c);
      if (c == SSC_CMD_CLS || c == SSC_CMD_QCLEAR) eq = 0;
      if (c == SSC_CMD_CLS) foreach (ev[i]) ev[i] = '0;
      if (c == SSC_CMD_STPRESET) for (int i = 1; i < 4; i++) en[i] = '0;
      rd(SSC_A_QSTAT, 32'(eq * 16 + oq));
      for (int i = 0; i < 4; i++) begin
        rd(SSC_A_ENABLE + 12'(4*i), {16'h0, en[i]});
        rd(SSC_A_EVENT + 12'(4*i), {16'h0, ev[i]});
        ev[i] = '0;
      end
      rd(SSC_A_STB, {24'h0, exp_sb()});
    end
    wr(SSC_A_ENABLE, 32'h0);
    rd(SSC_A_ENABLE, 32'h0);
    pulse(64'h2);
    fork
      wr(SSC_A_CMD, 32'h1);
      begin
        repeat (2) @(posedge pclk);
        event_in <= 64'h1;
        @(posedge pclk);
        event_in <= '0;
      end
    join
    rd(SSC_A_EVENT, 32'h1);
    tally_and_finish();
  end
endmodule : status_summary_and_clear_logic_tb
